// ===== design/cable_input_stage.sv
// Input register stage for cable signals
`timescale 1ns/100ps
`default_nettype none
module cable_input_stage #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : cable_input_stage
`default_nettype wire

// ===== design/disc_select_pkg.sv
// Constants shared by the unit select, seek and status logic
package disc_select_pkg;

  localparam int UNIT_W = 4;
  localparam int BUS_W = 10;
  localparam int REG_AW = 4;
  localparam int DATA_W = 32;
  localparam int RX_GROUPS = 3;
  localparam int STATUS_W = 14;

  // Register byte addresses
  localparam logic [REG_AW-1:0] CONFIG_OFS = 4'h0;
  localparam logic [REG_AW-1:0] STATUS_OFS = 4'h4;
  localparam logic [REG_AW-1:0] CYL_OFS = 4'h8;

  // Configuration fields
  localparam int CFG_MOVING_LSB = 0;
  localparam int CFG_FIXED_LSB = 4;
  localparam int CFG_CONTIG_BIT = 8;
  localparam int CFG_USED_W = 9;
  localparam logic [UNIT_W-1:0] CFG_MOVING_RST = 4'h0;
  localparam logic [UNIT_W-1:0] CFG_FIXED_RST = 4'h1;
  localparam logic CFG_CONTIG_RST = 1'b1;

  // Function bits on the bus lines, qualified by the function tag
  localparam int BIT_OFFSET_PLUS = 2;
  localparam int BIT_OFFSET_MINUS = 3;
  localparam int BIT_RESTORE = 6;

  // Timing
  localparam int CLK_NS = 4;
  localparam int SETTLE_NS = 30000;
  localparam int OFFSET_NS = 3000000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFFSET_CYCLES = (OFFSET_NS + CLK_NS - 1) / CLK_NS;

endpackage : disc_select_pkg

// ===== design/disc_unit_select_seek_status.sv
// Unit select, cable gating, seek strobe, track offset and seek status
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module disc_unit_select_seek_status #(
  parameter int SETTLE_CYCLES = disc_select_pkg::SETTLE_CYCLES,
  parameter int OFFSET_CYCLES = disc_select_pkg::OFFSET_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // Control cable
  input wire logic [disc_select_pkg::UNIT_W-1:0] unit_select_lines,
  input wire logic unit_tag,
  input wire logic [disc_select_pkg::BUS_W-1:0] bus_lines,
  input wire logic cylinder_tag,
  input wire logic function_tag,
  input wire logic cable_open_n,
  // Jumpers and drive state
  input wire logic maintenance_jumper_n,
  input wire logic fixed_disable_jumper_n,
  input wire logic drive_ready,
  input wire logic unit_ready_no_fault,
  // Servo and fixed-head address map
  input wire logic seek_complete,
  input wire logic seek_late,
  input wire logic illegal_cylinder,
  input wire logic illegal_fixed_address,
  // Register port
  input wire logic [disc_select_pkg::REG_AW-1:0] reg_addr,
  input wire logic [disc_select_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [disc_select_pkg::DATA_W-1:0] reg_rdata,
  // Selection and transceiver gating
  output logic moving_unit_selected,
  output logic fixed_unit_selected,
  output logic fixed_or_moving_select,
  output logic [disc_select_pkg::RX_GROUPS-1:0] receiver_disable,
  output logic [1:0] unit_selected_enable,
  output logic moving_tx_enable,
  output logic moving_wclk_rx_enable,
  output logic moving_wdata_rx_enable,
  output logic fixed_tx_enable,
  output logic fixed_wclk_rx_enable,
  output logic fixed_wdata_rx_enable,
  // Servo side
  output logic [disc_select_pkg::BUS_W-1:0] cylinder_address,
  output logic seek_strobe_out,
  output logic strobe_half_testpoint,
  output logic offset_plus_out,
  output logic offset_minus_out,
  output logic moving_restore,
  output logic fixed_restore,
  output logic fixed_address_strobe,
  // Status
  output logic track_offset_enable,
  output logic offset_edge_pulse,
  output logic moving_on_cylinder,
  output logic fixed_on_cylinder,
  output logic on_cylinder,
  output logic moving_seek_end,
  output logic fixed_seek_end,
  output logic moving_seek_error,
  output logic fixed_seek_error
);

  localparam int IN_W = disc_select_pkg::UNIT_W + disc_select_pkg::BUS_W + 12;

  ////////////////////////////////////////////////////////////////////////////
  // Input registers

  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] reg_in;
  logic [disc_select_pkg::UNIT_W-1:0] s_unit_lines;
  logic [disc_select_pkg::BUS_W-1:0] s_bus;
  logic s_unit_tag;
  logic s_cyl_tag;
  logic s_func_tag;
  logic s_cable_open_n;
  logic s_maintenance_n;
  logic s_fdis_n;
  logic s_drive_ready;
  logic s_unit_ready;
  logic s_seek_complete;
  logic s_seek_late;
  logic s_illegal_cyl;
  logic s_illegal_fixed;

  assign raw_in = {unit_select_lines, bus_lines, unit_tag, cylinder_tag,
                   function_tag, cable_open_n, maintenance_jumper_n,
                   fixed_disable_jumper_n, drive_ready, unit_ready_no_fault,
                   seek_complete, seek_late, illegal_cylinder,
                   illegal_fixed_address};

  // Cable lines are sampled once so every decision sees one stable copy
  cable_input_stage #(
    .W(IN_W)
  ) u_inputs (
    .clk(clk),
    .rst_n(rst_n),
    .d(raw_in),
    .q(reg_in)
  );

  assign {s_unit_lines, s_bus, s_unit_tag, s_cyl_tag, s_func_tag,
          s_cable_open_n, s_maintenance_n, s_fdis_n, s_drive_ready, s_unit_ready,
          s_seek_complete, s_seek_late, s_illegal_cyl,
          s_illegal_fixed} = reg_in;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  logic [disc_select_pkg::UNIT_W-1:0] moving_preset;
  logic [disc_select_pkg::UNIT_W-1:0] fixed_preset;
  logic contiguous_fixed;
  logic cfg_hit;
  logic cfg_write;

  assign cfg_hit = (reg_addr == disc_select_pkg::CONFIG_OFS);
  assign cfg_write = reg_write && cfg_hit;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      moving_preset <= disc_select_pkg::CFG_MOVING_RST;
      fixed_preset <= disc_select_pkg::CFG_FIXED_RST;
      contiguous_fixed <= disc_select_pkg::CFG_CONTIG_RST;
    end
    else if (cfg_write)
    begin
      moving_preset <= reg_wdata[disc_select_pkg::CFG_MOVING_LSB +:
                                 disc_select_pkg::UNIT_W];
      fixed_preset <= reg_wdata[disc_select_pkg::CFG_FIXED_LSB +:
                                disc_select_pkg::UNIT_W];
      contiguous_fixed <= reg_wdata[disc_select_pkg::CFG_CONTIG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit address latch and selection

  logic [disc_select_pkg::UNIT_W-1:0] unit_address;
  logic moving_match;
  logic fixed_match;
  logic next_moving_sel;
  logic next_fixed_sel;

  function automatic logic addr_match(
    input logic [disc_select_pkg::UNIT_W-1:0] a,
    input logic [disc_select_pkg::UNIT_W-1:0] b
  );
    addr_match = (a == b);
  endfunction : addr_match

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      unit_address <= '0;
    end
    else if (s_unit_tag)
    begin
      unit_address <= s_unit_lines;
    end
  end

  assign moving_match = addr_match(unit_address, moving_preset);
  // Fixed comparator is dead when the fixed option is jumpered out
  assign fixed_match = addr_match(unit_address, fixed_preset) && s_fdis_n;
  assign next_moving_sel = moving_match && s_cable_open_n && s_maintenance_n;
  assign next_fixed_sel = fixed_match && s_cable_open_n && s_maintenance_n;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      moving_unit_selected <= 1'b0;
      fixed_unit_selected <= 1'b0;
    end
    else
    begin
      moving_unit_selected <= next_moving_sel;
      fixed_unit_selected <= next_fixed_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transceiver gating

  logic any_selected;

  assign any_selected = moving_unit_selected || fixed_unit_selected;
  assign fixed_or_moving_select = !moving_unit_selected;
  // Floating receivers would oscillate on an open cable
  assign receiver_disable = {disc_select_pkg::RX_GROUPS{!s_cable_open_n}};
  assign unit_selected_enable = {2{any_selected}};
  assign moving_tx_enable = 1'b1;
  assign moving_wclk_rx_enable = s_cable_open_n;
  assign moving_wdata_rx_enable = moving_unit_selected;
  assign fixed_tx_enable = 1'b1;
  assign fixed_wclk_rx_enable = fixed_unit_selected;
  assign fixed_wdata_rx_enable = fixed_unit_selected;

  ////////////////////////////////////////////////////////////////////////////
  // Function decode, strobes and restores

  logic func_enable;
  logic next_seek;
  logic next_fixed_strobe;
  logic next_mrestore;
  logic next_frestore;
  logic next_off_plus;
  logic next_off_minus;
  logic offset_plus;
  logic offset_minus;
  logic seek_rise;

  assign func_enable = s_func_tag && s_drive_ready;
  assign next_seek = s_cyl_tag && moving_unit_selected && s_unit_ready;
  assign next_fixed_strobe = s_cyl_tag && fixed_unit_selected;
  assign next_mrestore = func_enable && moving_unit_selected &&
                         s_bus[disc_select_pkg::BIT_RESTORE];
  assign next_frestore = func_enable && fixed_unit_selected &&
                         s_bus[disc_select_pkg::BIT_RESTORE];
  assign next_off_plus = func_enable && any_selected &&
                         s_bus[disc_select_pkg::BIT_OFFSET_PLUS];
  assign next_off_minus = func_enable && any_selected &&
                          s_bus[disc_select_pkg::BIT_OFFSET_MINUS];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seek_strobe_out <= 1'b0;
      fixed_address_strobe <= 1'b0;
      moving_restore <= 1'b0;
      fixed_restore <= 1'b0;
      offset_plus <= 1'b0;
      offset_minus <= 1'b0;
    end
    else
    begin
      seek_strobe_out <= next_seek;
      fixed_address_strobe <= next_fixed_strobe;
      moving_restore <= next_mrestore;
      fixed_restore <= next_frestore;
      offset_plus <= next_off_plus;
      offset_minus <= next_off_minus;
    end
  end

  assign seek_rise = next_seek && !seek_strobe_out;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strobe_half_testpoint <= 1'b0;
    end
    else if (seek_rise)
    begin
      strobe_half_testpoint <= !strobe_half_testpoint;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cylinder_address <= '0;
      offset_plus_out <= 1'b0;
      offset_minus_out <= 1'b0;
    end
    else
    begin
      cylinder_address <= s_bus;
      offset_plus_out <= offset_plus && moving_unit_selected &&
                         track_offset_enable;
      offset_minus_out <= offset_minus && moving_unit_selected &&
                          track_offset_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Track offset enable and its edge pulse

  logic offset_req;
  logic toff_set;
  logic toff_clear;
  logic toff_prev;

  assign offset_req = offset_plus || offset_minus;
  assign toff_set = offset_req && on_cylinder;
  assign toff_clear = !offset_req || seek_strobe_out || moving_restore;

  // Set beats clear so an offset command taken with a strobe is kept
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      track_offset_enable <= 1'b0;
      toff_prev <= 1'b0;
    end
    else
    begin
      toff_prev <= track_offset_enable;
      if (toff_set)
      begin
        track_offset_enable <= 1'b1;
      end
      else if (toff_clear)
      begin
        track_offset_enable <= 1'b0;
      end
    end
  end

  assign offset_edge_pulse = track_offset_enable ^ toff_prev;

  ////////////////////////////////////////////////////////////////////////////
  // On-cylinder time-outs

  logic restart_timeout;
  logic settle_busy;
  logic offset_busy;
  logic moving_end_timeout;

  assign restart_timeout = seek_strobe_out || fixed_address_strobe ||
                           fixed_restore || moving_restore;

  retrig_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk(clk),
    .rst_n(rst_n),
    .start(restart_timeout),
    .busy(settle_busy)
  );

  // Holds moving on-cylinder off while the arm travels to or from the offset
  retrig_timer #(
    .CYCLES(OFFSET_CYCLES)
  ) u_offset (
    .clk(clk),
    .rst_n(rst_n),
    .start(offset_edge_pulse),
    .busy(offset_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Seek errors

  logic fixed_err_set;

  assign fixed_err_set = s_illegal_fixed && contiguous_fixed &&
                         fixed_address_strobe;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      moving_seek_error <= 1'b0;
      fixed_seek_error <= 1'b0;
    end
    else
    begin
      if (s_seek_late || s_illegal_cyl)
      begin
        moving_seek_error <= 1'b1;
      end
      else if (moving_restore)
      begin
        moving_seek_error <= 1'b0;
      end
      if (fixed_err_set)
      begin
        fixed_seek_error <= 1'b1;
      end
      else if (fixed_restore)
      begin
        fixed_seek_error <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // On-cylinder and seek end

  logic next_mon;
  logic next_fon;

  assign next_mon = !settle_busy && !offset_busy && !moving_seek_error &&
                    (s_seek_complete || track_offset_enable);
  assign next_fon = !settle_busy && !fixed_seek_error;
  assign moving_end_timeout = moving_unit_selected && settle_busy;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      moving_on_cylinder <= 1'b0;
      fixed_on_cylinder <= 1'b0;
      moving_seek_end <= 1'b0;
      fixed_seek_end <= 1'b0;
    end
    else
    begin
      moving_on_cylinder <= next_mon;
      fixed_on_cylinder <= next_fon;
      moving_seek_end <= (moving_seek_error || moving_on_cylinder) &&
                         !moving_end_timeout;
      fixed_seek_end <= (fixed_seek_error || fixed_on_cylinder) &&
                        !settle_busy;
    end
  end

  // Cable status follows whichever unit is selected
  assign on_cylinder = moving_unit_selected ? moving_on_cylinder :
                       fixed_on_cylinder;

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  logic [disc_select_pkg::STATUS_W-1:0] status_bits;
  logic [disc_select_pkg::DATA_W-1:0] next_rdata;

  assign status_bits = {strobe_half_testpoint, fixed_seek_end, moving_seek_end,
                        track_offset_enable, fixed_on_cylinder,
                        moving_on_cylinder, fixed_seek_error, moving_seek_error,
                        fixed_unit_selected, moving_unit_selected, unit_address};

  // Unmapped addresses read as zero
  always_comb
  begin
    next_rdata = '0;
    unique case (reg_addr)
      disc_select_pkg::CONFIG_OFS:
        next_rdata[disc_select_pkg::CFG_USED_W-1:0] =
          {contiguous_fixed, fixed_preset, moving_preset};
      disc_select_pkg::STATUS_OFS:
        next_rdata[disc_select_pkg::STATUS_W-1:0] = status_bits;
      disc_select_pkg::CYL_OFS:
        next_rdata[disc_select_pkg::BUS_W-1:0] = cylinder_address;
      default:
        next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= '0;
    end
    else if (reg_read)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

endmodule : disc_unit_select_seek_status
`default_nettype wire

// ===== design/retrig_timer.sv
// Retriggerable one-shot: busy for CYCLES clocks after the last start
`timescale 1ns/100ps
`default_nettype none
module retrig_timer #(
  parameter int CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] count;

  // A start while running reloads, so the window follows the latest event
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count <= '0;
    end
    else if (start)
    begin
      count <= LOAD;
    end
    else if (count != '0)
    begin
      count <= count - ONE;
    end
  end

  assign busy = (count != '0);

endmodule : retrig_timer
`default_nettype wire

// ===== dv/disc_select_asserts.sv
// Concurrent checks on the select, seek and status ports
`timescale 1ns/100ps
`default_nettype none
module disc_select_asserts #(
  parameter int SETTLE_CYCLES = 20,
  parameter int OFFSET_CYCLES = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cylinder_tag,
  input wire logic unit_ready_no_fault,
  input wire logic [disc_select_pkg::BUS_W-1:0] bus_lines,
  input wire logic moving_unit_selected,
  input wire logic fixed_unit_selected,
  input wire logic fixed_or_moving_select,
  input wire logic [disc_select_pkg::RX_GROUPS-1:0] receiver_disable,
  input wire logic [1:0] unit_selected_enable,
  input wire logic [disc_select_pkg::BUS_W-1:0] cylinder_address,
  input wire logic seek_strobe_out,
  input wire logic strobe_half_testpoint,
  input wire logic offset_plus_out,
  input wire logic moving_restore,
  input wire logic track_offset_enable,
  input wire logic offset_edge_pulse,
  input wire logic moving_on_cylinder,
  input wire logic fixed_on_cylinder,
  input wire logic moving_seek_end,
  input wire logic moving_seek_error
);
  default clocking main_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence strobe_rise;
    $rose(seek_strobe_out);
  endsequence
  sequence settle_drop;
    ##[1:4] !fixed_on_cylinder;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_FOM_SELECT: assert property (fixed_or_moving_select == !moving_unit_selected)
    else $error("data path select disagrees with moving selection");
  AST_TX_GATE: assert property (unit_selected_enable ==
    {2{moving_unit_selected || fixed_unit_selected}})
    else $error("transmitter enable disagrees with selection");
  AST_OPEN_DESELECT: assert property (receiver_disable[0] [*2] |=>
    !(moving_unit_selected || fixed_unit_selected))
    else $error("unit stays selected during open cable");
  AST_SEEK_QUALIFY: assert property (seek_strobe_out |-> $past(moving_unit_selected)
    && $past(cylinder_tag, 2) && $past(unit_ready_no_fault, 2))
    else $error("seek strobe without tag, selection or ready");
  AST_TESTPOINT: assert property (strobe_rise |-> ##[0:1] $changed(strobe_half_testpoint))
    else $error("test point did not toggle on seek strobe");
  AST_CYL_PASS: assert property (cylinder_address == $past(bus_lines, 2))
    else $error("cylinder address does not follow bus lines");
  AST_OFFSET_GATE: assert property (offset_plus_out |->
    $past(track_offset_enable) && $past(moving_unit_selected))
    else $error("offset forwarded without enable or selection");
  AST_OFFSET_EDGE: assert property ($changed(track_offset_enable) |-> offset_edge_pulse)
    else $error("no edge pulse on offset enable change");
  AST_RESTART: assert property (strobe_rise |-> settle_drop)
    else $error("on-cylinder not dropped after seek strobe");
  AST_MERR_HOLD: assert property (moving_seek_error && !moving_restore |=> moving_seek_error)
    else $error("seek error cleared without restore");
  AST_ERR_ON_CYLINDER: assert property (moving_seek_error [*2] |-> !moving_on_cylinder)
    else $error("on-cylinder during seek error");
  AST_SEEK_END: assert property (moving_seek_end |->
    $past(moving_seek_error || moving_on_cylinder))
    else $error("seek end without on-cylinder or error");
endmodule : disc_select_asserts
`default_nettype wire

// ===== dv/disc_unit_select_seek_status_test.sv
// Directed bench for the unit select, seek and status block
`timescale 1ns/100ps
`default_nettype none
module disc_unit_select_seek_status_test;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] unit_select_lines = 4'h0;
  logic [9:0] bus_lines = 10'h000;
  logic unit_tag = 1'b0, cylinder_tag = 1'b0, function_tag = 1'b0;
  logic cable_open_n = 1'b1, maintenance_jumper_n = 1'b1, fixed_disable_jumper_n = 1'b1;
  logic drive_ready = 1'b1, unit_ready_no_fault = 1'b1, illegal_fixed_address = 1'b0;
  logic late_mode = 1'b0, slow = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000, reg_rdata, v;
  logic seek_complete, seek_late, illegal_cylinder, tp;
  logic moving_unit_selected, fixed_unit_selected, fixed_or_moving_select;
  logic [2:0] receiver_disable;
  logic [1:0] unit_selected_enable;
  logic moving_tx_enable, moving_wclk_rx_enable, moving_wdata_rx_enable;
  logic fixed_tx_enable, fixed_wclk_rx_enable, fixed_wdata_rx_enable;
  logic [9:0] cylinder_address;
  logic seek_strobe_out, strobe_half_testpoint, offset_plus_out, offset_minus_out;
  logic moving_restore, track_offset_enable, offset_edge_pulse, on_cylinder;
  logic moving_on_cylinder, fixed_on_cylinder, moving_seek_end, fixed_seek_end;
  logic moving_seek_error, fixed_seek_error;
  int errors = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  disc_unit_select_seek_status #(.SETTLE_CYCLES(SETTLE), .OFFSET_CYCLES(40)) DUT (
    .*, .fixed_restore(), .fixed_address_strobe());

  servo_model #(.SEEK_CYCLES(12), .MAX_CYL(10'h31F)) servo (
    .*, .restore(moving_restore));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Ends just after an edge so outputs have settled before sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic await(ref logic s, input logic val);
    for (int i = 0; i < 400 && s !== val; i++)
      step(1);
    chk(s, val);
    if (s !== val)
      give_verdict();
  endtask : await

  task automatic quiet(ref logic s, input int n);
    repeat (n)
    begin
      step(1);
      chk(s, 1'b0);
    end
  endtask : quiet

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic sel(input logic [3:0] u);
    @(posedge clk);
    unit_select_lines <= u;
    unit_tag <= 1'b1;
    @(posedge clk);
    unit_tag <= 1'b0;
    step(4);
  endtask : sel

  // Mode bits: late seek, slow seek, bad fixed address, unit ready
  task automatic seek(input logic [9:0] c, input logic [3:0] m);
    @(posedge clk);
    bus_lines <= c;
    {late_mode, slow, illegal_fixed_address, unit_ready_no_fault} <= m;
    cylinder_tag <= 1'b1;
    @(posedge clk);
    cylinder_tag <= 1'b0;
  endtask : seek

  task automatic func(input logic [9:0] b, input logic on);
    @(posedge clk);
    bus_lines <= b;
    function_tag <= on;
  endtask : func
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(disc_select_pkg::CONFIG_OFS, v);
    chk(v, 32'h00000110);
    rd(4'hC, v);
    chk(v, 32'h00000000);
    wr(disc_select_pkg::CYL_OFS, 32'h000003FF);
    rd(disc_select_pkg::CYL_OFS, v);
    chk(v, 32'h00000000);
    wr(disc_select_pkg::CONFIG_OFS, 32'h000001F3);
    rd(disc_select_pkg::CONFIG_OFS, v);
    chk(v, 32'h000001F3);
    sel(4'h3);
    rd(disc_select_pkg::STATUS_OFS, v);
    chk(v[5:0], 6'h13);
    chk({fixed_or_moving_select, unit_selected_enable, receiver_disable}, 6'h18);
    chk({moving_wdata_rx_enable, moving_wclk_rx_enable, moving_tx_enable}, 3'h7);
    chk({fixed_tx_enable, fixed_wdata_rx_enable, fixed_wclk_rx_enable}, 3'h4);
    tp = strobe_half_testpoint;
    seek(10'h155, 4'h1);
    await(seek_strobe_out, 1'b1);
    step(1);
    chk({strobe_half_testpoint, cylinder_address}, {~tp, 10'h155});
    rd(disc_select_pkg::CYL_OFS, v);
    chk(v, 32'h00000155);
    await(moving_on_cylinder, 1'b1);
    await(moving_seek_end, 1'b1);
    chk(fixed_on_cylinder, 1'b1);
    seek(10'h0AA, 4'h5);
    await(seek_strobe_out, 1'b1);
    step(2);
    quiet(moving_on_cylinder, SETTLE - 4);
    await(moving_on_cylinder, 1'b1);
    seek(10'h0F0, 4'h0);
    quiet(seek_strobe_out, 6);
    for (int i = 0; i < 2; i++)
    begin
      await(moving_on_cylinder, 1'b1);
      func(10'h004 << i, 1'b1);
      await(track_offset_enable, 1'b1);
      step(3);
      chk({offset_minus_out, offset_plus_out, moving_on_cylinder}, {2'b01 << i, 1'b0});
      func(10'h000, 1'b0);
      await(track_offset_enable, 1'b0);
      step(2);
      chk({offset_minus_out, offset_plus_out}, 2'b00);
    end
    for (int i = 0; i < 2; i++)
    begin
      seek(i ? 10'h010 : 10'h3FF, i ? 4'h9 : 4'h1);
      await(moving_seek_error, 1'b1);
      step(5);
      chk(moving_seek_error, 1'b1);
      func(10'h040, 1'b1);
      func(10'h040, 1'b0);
      await(moving_seek_error, 1'b0);
    end
    sel(4'hF);
    rd(disc_select_pkg::STATUS_OFS, v);
    chk(v[5:0], 6'h2F);
    chk({fixed_or_moving_select, fixed_wdata_rx_enable, fixed_wclk_rx_enable}, 3'h7);
    seek(10'h001, 4'h3);
    quiet(seek_strobe_out, 4);
    await(fixed_seek_error, 1'b1);
    seek(10'h001, 4'h1);
    step(5);
    chk({fixed_seek_error, fixed_on_cylinder, fixed_seek_end, on_cylinder}, 4'h8);
    func(10'h040, 1'b1);
    func(10'h040, 1'b0);
    await(fixed_seek_error, 1'b0);
    await(fixed_seek_end, 1'b1);
    chk(on_cylinder, 1'b1);
    @(posedge clk);
    cable_open_n <= 1'b0;
    step(4);
    chk({receiver_disable, moving_wclk_rx_enable, fixed_unit_selected}, 5'h1C);
    @(posedge clk);
    cable_open_n <= 1'b1;
    maintenance_jumper_n <= 1'b0;
    sel(4'h3);
    quiet(moving_unit_selected, 6);
    @(posedge clk);
    {maintenance_jumper_n, fixed_disable_jumper_n} <= 2'b10;
    sel(4'hF);
    quiet(fixed_unit_selected, 6);
    give_verdict();
  end
endmodule : disc_unit_select_seek_status_test

bind disc_unit_select_seek_status disc_select_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .OFFSET_CYCLES(OFFSET_CYCLES)) u_check (.*);
`default_nettype wire

// ===== dv/servo_model.sv
// Servo stand-in: answers seek strobes and restores with completion or errors
`timescale 1ns/100ps
`default_nettype none
module servo_model #(
  parameter int SEEK_CYCLES = 12,
  parameter logic [9:0] MAX_CYL = 10'h31F
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic late_mode,
  input wire logic slow,
  input wire logic restore,
  input wire logic seek_strobe_out,
  input wire logic [9:0] cylinder_address,
  output logic seek_complete,
  output logic seek_late,
  output logic illegal_cylinder
);
  int count;
  logic strobe_d;
  logic was_strobe;
  logic start;
  logic bad;
  assign start = (seek_strobe_out && !strobe_d) || restore;
  assign bad = seek_strobe_out && !strobe_d && (cylinder_address > MAX_CYL);
  ////////////////////////////////////////////////////////////////////////////////
  // A rejected or late seek never completes: only a restore brings the arm home
  always_ff @(posedge clk)
  begin
    strobe_d <= seek_strobe_out;
    illegal_cylinder <= bad;
    seek_late <= (count == 1) && late_mode && was_strobe;
    if (!rst_n)
    begin
      count <= 0;
      seek_complete <= 1'b1;
    end
    else if (start)
    begin
      count <= bad ? 0 : (slow ? 4 * SEEK_CYCLES : SEEK_CYCLES);
      was_strobe <= !restore;
      seek_complete <= 1'b0;
    end
    else if (count > 0)
    begin
      count <= count - 1;
      if (count == 1)
        seek_complete <= !(late_mode && was_strobe);
    end
  end
endmodule : servo_model
`default_nettype wire
